// [shared/qmcs_pkg.sv]
// How it works
// - tx free bytes in bits 12-0, read-only
// - free count covers payload and control word
// - host checks free space before writing frame
// - rx pending bytes in bits 12-0, read-only
// - receive queue holds 4096 bytes total
// - rx count changes only on complete packets
// - rx completion interrupts only when bit 13 enabled
// - host drains promptly; device drops frames lacking room
// - writing one to bit 0 enqueues frame
// - enqueue bit self-clears when transmission finishes
// - host polls enqueue bit before next frame
// - writing one to bit 0 releases rx frame
// - release bit reads one until space freed
// - host polls release bit before next frame
// - enqueue resets tx frame pointer
// - release resets rx frame pointer
package qmcs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W = 13;
    localparam int PTR_W = 11;
    localparam int RX_QUEUE_BYTES = 4096;

    // device register offsets on the queue bus
    localparam logic [7:0] OFF_TX_CMD = 8'h00;
    localparam logic [7:0] OFF_RX_CMD = 8'h02;
    localparam logic [7:0] OFF_TX_PTR = 8'h04;
    localparam logic [7:0] OFF_RX_PTR = 8'h06;
    localparam logic [7:0] OFF_TX_FREE = 8'h08;
    localparam logic [7:0] OFF_RX_COUNT = 8'h0a;
    localparam logic [7:0] OFF_INT_EN = 8'h10;
    localparam logic [7:0] OFF_INT_STAT = 8'h12;
    localparam logic [7:0] OFF_INT_CLR = 8'h14;

    // field positions and fixed sizes
    localparam int CMD_BIT = 0;
    localparam int RX_INT_BIT = 13;
    localparam int TX_INT_BIT = 14;
    localparam logic [15:0] INT_MASK = 16'h6000;
    localparam logic [12:0] CTRL_WORD_BYTES = 13'h004;
    localparam logic [12:0] STATUS_WORD_BYTES = 13'h004;

    // host controller apb map
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_LEN = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam logic [7:0] APB_TX_FREE = 8'h0c;
    localparam logic [7:0] APB_RX_COUNT = 8'h10;
    localparam int CTL_SEND = 0;
    localparam int CTL_RELEASE = 1;
    localparam int CTL_REFRESH = 2;
    localparam int CTL_IRQ_EN = 3;
    localparam logic [15:0] RX_INT_EN_WORD = 16'h2000;
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_TX_DONE = 2;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_RD_FREE = 3'b001,
        HS_WR_TXCMD = 3'b010,
        HS_POLL_TX = 3'b011,
        HS_WR_RXCMD = 3'b100,
        HS_POLL_RX = 3'b101,
        HS_RD_RXCNT = 3'b110,
        HS_WR_INTEN = 3'b111
    } qmcs_host_state_t;
endpackage

// [shared/qmcs_bus_if.sv]
// register path between the queue host and the queue device
interface qmcs_bus_if;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;

    modport dev (
        input req,
        input wr,
        input addr,
        input wdata,
        output rdata,
        output ack
    );
    modport host (
        output req,
        output wr,
        output addr,
        output wdata,
        input rdata,
        input ack
    );
endinterface

// [hw/qmcs_device.sv]
// Implementation choice: the queue bus register port.
module qmcs_device
    import qmcs_pkg::*;
#(
    parameter int TX_QUEUE_BYTES = 4096,
    parameter int RX_SLOTS = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    qmcs_bus_if.dev bus,
    input wire logic [CNT_W-1:0] tx_frame_bytes,
    input wire logic tx_done,
    input wire logic rx_frame_done,
    input wire logic [CNT_W-1:0] rx_frame_bytes,
    output logic tx_start,
    output logic rx_drop,
    output logic rx_irq,
    output logic [PTR_W-1:0] tx_frame_pointer,
    output logic [PTR_W-1:0] rx_frame_pointer
);
    localparam int IDX_W = $clog2(RX_SLOTS);
    localparam int FILL_W = $clog2(RX_SLOTS + 1);

    // index wrap relies on a power-of-two slot count
    if (RX_SLOTS < 2 || (RX_SLOTS & (RX_SLOTS - 1)) != 0) begin : g_bad_slots
        $error("RX_SLOTS must be a power of two of at least 2");
    end
    if (TX_QUEUE_BYTES < 1 || TX_QUEUE_BYTES > 8191) begin : g_bad_tx
        $error("TX_QUEUE_BYTES must fit the 13-bit count");
    end

    logic ack_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic tx_pend_reg;
    logic [CNT_W-1:0] tx_size_reg;
    logic [CNT_W-1:0] tx_free_reg;
    logic tx_start_reg;
    logic [PTR_W-1:0] tx_ptr_reg;
    logic rx_rel_reg;
    logic [CNT_W-1:0] rx_count_reg;
    logic [PTR_W-1:0] rx_ptr_reg;
    logic [CNT_W-1:0] size_mem [RX_SLOTS];
    logic [IDX_W-1:0] wr_idx_reg;
    logic [IDX_W-1:0] rd_idx_reg;
    logic [FILL_W-1:0] fill_reg;
    logic [DATA_W-1:0] int_en_reg;
    logic [DATA_W-1:0] int_stat_reg;
    logic [DATA_W-1:0] int_stat_next;
    logic rx_irq_reg;
    logic rx_drop_reg;

    logic take;
    logic tx_fire;
    logic tx_finish;
    logic rx_fire;
    logic rx_pop;
    logic rx_accept;
    logic [CNT_W-1:0] tx_total;
    logic [CNT_W-1:0] rx_total;
    logic [CNT_W:0] rx_sum;

    // one access per request: ack drops the cycle after it rises
    assign take = bus.req && !ack_reg;
    assign tx_total = tx_frame_bytes + CTRL_WORD_BYTES;
    assign rx_total = rx_frame_bytes + STATUS_WORD_BYTES;
    assign rx_sum = {1'b0, rx_count_reg} + {1'b0, rx_total};
    assign tx_fire = take && bus.wr && bus.addr == OFF_TX_CMD && bus.wdata[CMD_BIT] && !tx_pend_reg;
    assign tx_finish = tx_pend_reg && tx_done;
    assign rx_fire = take && bus.wr && bus.addr == OFF_RX_CMD && bus.wdata[CMD_BIT] && !rx_rel_reg;
    // freeing takes place the cycle after the command, with the head size
    assign rx_pop = rx_rel_reg && fill_reg != '0;
    assign rx_accept = rx_frame_done && rx_sum <= (CNT_W + 1)'(RX_QUEUE_BYTES)
        && fill_reg != FILL_W'(RX_SLOTS);

    // bus answer, registered one cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            ack_reg <= take;
            if (take && !bus.wr) begin
                if (bus.addr == OFF_TX_CMD) begin
                    rdata_reg <= {15'h0000, tx_pend_reg};
                end else if (bus.addr == OFF_RX_CMD) begin
                    rdata_reg <= {15'h0000, rx_rel_reg};
                end else if (bus.addr == OFF_TX_PTR) begin
                    rdata_reg <= {5'h00, tx_ptr_reg};
                end else if (bus.addr == OFF_RX_PTR) begin
                    rdata_reg <= {5'h00, rx_ptr_reg};
                end else if (bus.addr == OFF_TX_FREE) begin
                    rdata_reg <= {3'h0, tx_free_reg};
                end else if (bus.addr == OFF_RX_COUNT) begin
                    rdata_reg <= {3'h0, rx_count_reg};
                end else if (bus.addr == OFF_INT_EN) begin
                    rdata_reg <= int_en_reg;
                end else if (bus.addr == OFF_INT_STAT) begin
                    rdata_reg <= int_stat_reg;
                end else begin
                    rdata_reg <= 16'h0000; // unmapped reads zero
                end
            end
        end
    end

    // transmit enqueue and free space
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pend_reg <= 1'b0;
            tx_size_reg <= 13'h0000;
            tx_free_reg <= CNT_W'(TX_QUEUE_BYTES);
            tx_start_reg <= 1'b0;
        end else begin
            tx_start_reg <= tx_fire;
            if (tx_fire) begin
                tx_pend_reg <= 1'b1;
                tx_size_reg <= tx_total;
                tx_free_reg <= tx_free_reg - tx_total;
            end else if (tx_finish) begin
                tx_pend_reg <= 1'b0;
                tx_free_reg <= tx_free_reg + tx_size_reg;
            end
        end
    end

    // frame pointers: host writable, reset by the commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ptr_reg <= 11'h000;
            rx_ptr_reg <= 11'h000;
        end else begin
            if (tx_fire) begin
                tx_ptr_reg <= 11'h000;
            end else if (take && bus.wr && bus.addr == OFF_TX_PTR) begin
                tx_ptr_reg <= bus.wdata[PTR_W-1:0];
            end
            if (rx_rel_reg) begin
                rx_ptr_reg <= 11'h000;
            end else if (take && bus.wr && bus.addr == OFF_RX_PTR) begin
                rx_ptr_reg <= bus.wdata[PTR_W-1:0];
            end
        end
    end

    // frame sizes waiting in the receive queue, oldest first
    always_ff @(posedge pclk) begin
        if (rx_accept) begin
            size_mem[wr_idx_reg] <= rx_total;
        end
    end

    // receive count, release and drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_rel_reg <= 1'b0;
            rx_count_reg <= 13'h0000;
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            fill_reg <= '0;
            rx_drop_reg <= 1'b0;
        end else begin
            rx_drop_reg <= rx_frame_done && !rx_accept;
            if (rx_fire) begin
                rx_rel_reg <= 1'b1;
            end else if (rx_rel_reg) begin
                rx_rel_reg <= 1'b0;
            end
            rx_count_reg <= rx_count_reg + (rx_accept ? rx_total : 13'h0000)
                - (rx_pop ? size_mem[rd_idx_reg] : 13'h0000);
            if (rx_accept) begin
                wr_idx_reg <= wr_idx_reg + IDX_W'(1);
            end
            if (rx_pop) begin
                rd_idx_reg <= rd_idx_reg + IDX_W'(1);
            end
            fill_reg <= fill_reg + (rx_accept ? FILL_W'(1) : FILL_W'(0)) - (rx_pop ? FILL_W'(1) : FILL_W'(0));
        end
    end

    // sticky status: a new event beats a clear in the same cycle
    always_comb begin
        int_stat_next = int_stat_reg;
        if (take && bus.wr && bus.addr == OFF_INT_CLR) begin
            int_stat_next = int_stat_next & ~bus.wdata;
        end
        if (rx_accept) begin
            int_stat_next[RX_INT_BIT] = 1'b1;
        end
        if (tx_finish) begin
            int_stat_next[TX_INT_BIT] = 1'b1;
        end
    end

    // interrupt enable, status and output level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_reg <= 16'h0000;
            int_stat_reg <= 16'h0000;
            rx_irq_reg <= 1'b0;
        end else begin
            if (take && bus.wr && bus.addr == OFF_INT_EN) begin
                int_en_reg <= bus.wdata & INT_MASK;
            end
            int_stat_reg <= int_stat_next;
            rx_irq_reg <= |(int_stat_next & int_en_reg);
        end
    end

    assign bus.ack = ack_reg;
    assign bus.rdata = rdata_reg;
    assign tx_start = tx_start_reg;
    assign rx_drop = rx_drop_reg;
    assign rx_irq = rx_irq_reg;
    assign tx_frame_pointer = tx_ptr_reg;
    assign rx_frame_pointer = rx_ptr_reg;
endmodule

// [hw/qmcs_host.sv]
module qmcs_host
    import qmcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    qmcs_bus_if.host bus
);
    qmcs_host_state_t state_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [CNT_W-1:0] len_reg;
    logic refused_reg;
    logic tx_done_reg;
    logic [CNT_W-1:0] tx_free_reg;
    logic [CNT_W-1:0] rx_count_reg;
    logic req_reg;
    logic wr_reg;
    logic [7:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [7:0] op_addr;
    logic op_wr;
    logic apb_wr;
    logic done;
    logic [CNT_W:0] need;

    assign apb_wr = psel && penable && pready_reg && pwrite;
    assign done = req_reg && bus.ack;
    assign need = {1'b0, len_reg} + {1'b0, CTRL_WORD_BYTES};

    // apb slave: answer prepared in setup, one access cycle, no waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= psel && !penable;
            if (psel && !penable) begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h00000000;
                if (paddr == APB_CTRL) begin
                    prdata_reg <= 32'h00000000;
                end else if (paddr == APB_LEN) begin
                    prdata_reg <= {19'h00000, len_reg};
                end else if (paddr == APB_STATUS) begin
                    prdata_reg <= {29'h00000000, tx_done_reg, refused_reg, state_reg != HS_IDLE};
                end else if (paddr == APB_TX_FREE) begin
                    prdata_reg <= {19'h00000, tx_free_reg};
                end else if (paddr == APB_RX_COUNT) begin
                    prdata_reg <= {19'h00000, rx_count_reg};
                end else begin
                    pslverr_reg <= 1'b1;
                end
            end
        end
    end

    // frame length written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_reg <= 13'h0000;
        end else if (apb_wr && paddr == APB_LEN) begin
            len_reg <= pwdata[CNT_W-1:0];
        end
    end

    // device access that each state needs
    always_comb begin
        op_addr = OFF_TX_FREE;
        op_wr = 1'b0;
        case (state_reg)
            HS_WR_TXCMD: begin
                op_addr = OFF_TX_CMD;
                op_wr = 1'b1;
            end
            HS_POLL_TX: op_addr = OFF_TX_CMD;
            HS_WR_RXCMD: begin
                op_addr = OFF_RX_CMD;
                op_wr = 1'b1;
            end
            HS_POLL_RX: op_addr = OFF_RX_CMD;
            HS_RD_RXCNT: op_addr = OFF_RX_COUNT;
            HS_WR_INTEN: begin
                op_addr = OFF_INT_EN;
                op_wr = 1'b1;
            end
            default: op_addr = OFF_TX_FREE;
        endcase
    end

    // bus master: request held until the device acks it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdata_reg <= 16'h0000;
        end else if (done) begin
            req_reg <= 1'b0;
        end else if (!req_reg && state_reg != HS_IDLE) begin
            req_reg <= 1'b1;
            wr_reg <= op_wr;
            addr_reg <= op_addr;
            // the enable write is the only one that is not a bare command bit
            wdata_reg <= (state_reg == HS_WR_INTEN) ? RX_INT_EN_WORD : (op_wr ? 16'h0001 : 16'h0000);
        end
    end

    // command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HS_IDLE;
            refused_reg <= 1'b0;
            tx_done_reg <= 1'b0;
            tx_free_reg <= 13'h0000;
            rx_count_reg <= 13'h0000;
        end else begin
            case (state_reg)
                HS_IDLE: begin
                    if (apb_wr && paddr == APB_CTRL) begin
                        if (pwdata[CTL_SEND]) begin
                            refused_reg <= 1'b0;
                            tx_done_reg <= 1'b0;
                            state_reg <= HS_RD_FREE;
                        end else if (pwdata[CTL_RELEASE]) begin
                            state_reg <= HS_WR_RXCMD;
                        end else if (pwdata[CTL_REFRESH]) begin
                            state_reg <= HS_RD_RXCNT;
                        end else if (pwdata[CTL_IRQ_EN]) begin
                            state_reg <= HS_WR_INTEN;
                        end
                    end
                end
                HS_RD_FREE: begin
                    if (done) begin
                        tx_free_reg <= bus.rdata[CNT_W-1:0];
                        if ({1'b0, bus.rdata[CNT_W-1:0]} >= need) begin
                            state_reg <= HS_WR_TXCMD;
                        end else begin
                            refused_reg <= 1'b1;
                            state_reg <= HS_IDLE;
                        end
                    end
                end
                HS_WR_TXCMD: begin
                    if (done) begin
                        state_reg <= HS_POLL_TX;
                    end
                end
                HS_POLL_TX: begin
                    if (done && !bus.rdata[CMD_BIT]) begin
                        tx_done_reg <= 1'b1;
                        state_reg <= HS_IDLE;
                    end
                end
                HS_WR_RXCMD: begin
                    if (done) begin
                        state_reg <= HS_POLL_RX;
                    end
                end
                HS_POLL_RX: begin
                    if (done && !bus.rdata[CMD_BIT]) begin
                        state_reg <= HS_RD_RXCNT;
                    end
                end
                HS_RD_RXCNT: begin
                    if (done) begin
                        rx_count_reg <= bus.rdata[CNT_W-1:0];
                        state_reg <= HS_IDLE;
                    end
                end
                HS_WR_INTEN: begin
                    if (done) begin
                        state_reg <= HS_IDLE;
                    end
                end
                default: state_reg <= HS_IDLE;
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign bus.req = req_reg;
    assign bus.wr = wr_reg;
    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
endmodule

// [sim/qmcs_assertions.sv]
// watches the queue bus between host and device, plus the device side pins
module qmcs_assertions
    import qmcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic tx_start,
    input wire logic rx_frame_done,
    input wire logic rx_drop,
    input wire logic rx_irq,
    input wire logic [10:0] tx_frame_pointer,
    input wire logic [10:0] rx_frame_pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // until the enable register is written, no rx interrupt may appear
    logic en_written_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_written_reg <= 1'b0;
        else if (req && !ack && wr && addr == OFF_INT_EN)
            en_written_reg <= 1'b1;
    end

    // taken command writes with the command bit set, and a taken read of the rx command register
    sequence s_tx_taken;
        req && !ack && wr && addr == OFF_TX_CMD && wdata[CMD_BIT];
    endsequence
    sequence s_rel_taken;
        req && !ack && wr && addr == OFF_RX_CMD && wdata[CMD_BIT];
    endsequence
    sequence s_rx_cmd_read;
        req && !ack && !wr && addr == OFF_RX_CMD;
    endsequence

    property p_ack_answer;
        req && !ack |=> ack ##1 !ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack not a single pulse after request");
    property p_tx_start;
        tx_start |-> $past(req && !ack && wr && addr == OFF_TX_CMD && wdata[CMD_BIT]);
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("enqueue start without command write");
    property p_tx_ptr;
        s_tx_taken ##1 tx_start |-> tx_frame_pointer == 11'h000;
    endproperty
    a_tx_ptr: assert property (p_tx_ptr) else $error("tx pointer not reset on enqueue");
    property p_rel_ptr;
        s_rel_taken |-> ##2 rx_frame_pointer == 11'h000;
    endproperty
    a_rel_ptr: assert property (p_rel_ptr) else $error("rx pointer not reset on release");
    property p_rel_clears;
        s_rel_taken ##3 s_rx_cmd_read |=> rdata[CMD_BIT] == 1'b0;
    endproperty
    a_rel_clears: assert property (p_rel_clears) else $error("release bit still set after freeing");
    property p_cmd_reserved;
        ack && !wr && (addr == OFF_TX_CMD || addr == OFF_RX_CMD) |-> rdata[15:1] == 15'h0000;
    endproperty
    a_cmd_reserved: assert property (p_cmd_reserved) else $error("command reserved bits nonzero");
    property p_count_field;
        ack && !wr && (addr == OFF_TX_FREE || addr == OFF_RX_COUNT) |-> rdata[15:13] == 3'h0;
    endproperty
    a_count_field: assert property (p_count_field) else $error("count upper bits nonzero");
    property p_rx_capacity;
        ack && !wr && addr == OFF_RX_COUNT |-> rdata[12:0] <= 13'd4096;
    endproperty
    a_rx_capacity: assert property (p_rx_capacity) else $error("rx count above capacity");
    property p_drop;
        rx_drop |-> $past(rx_frame_done);
    endproperty
    a_drop: assert property (p_drop) else $error("drop without arriving frame");
    property p_irq_masked;
        !en_written_reg |-> !rx_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("rx interrupt while disabled");
endmodule

// [sim/testbench.sv]
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_total++; $display("mismatch %s expected %0h seen %0h", nm, (exp), (got)); end end

module testbench
    import qmcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_done, rx_frame_done, tx_start, rx_drop, rx_irq;
    logic er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] tx_frame_bytes, rx_frame_bytes;
    logic [10:0] tx_frame_pointer, rx_frame_pointer;
    int err_total, total_checks, cycles, tx_starts, drops, rx_cnt;
    int rx_q[$];

    qmcs_bus_if qmcs_bus_if_inst ();
    qmcs_device qmcs_device_inst (.pclk(pclk), .presetn(presetn), .bus(qmcs_bus_if_inst.dev),
        .tx_frame_bytes(tx_frame_bytes), .tx_done(tx_done), .rx_frame_done(rx_frame_done),
        .rx_frame_bytes(rx_frame_bytes), .tx_start(tx_start), .rx_drop(rx_drop), .rx_irq(rx_irq),
        .tx_frame_pointer(tx_frame_pointer), .rx_frame_pointer(rx_frame_pointer));
    qmcs_host qmcs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(qmcs_bus_if_inst.host));
    qmcs_assertions qmcs_assertions_inst (.pclk(pclk), .presetn(presetn), .req(qmcs_bus_if_inst.req),
        .wr(qmcs_bus_if_inst.wr), .addr(qmcs_bus_if_inst.addr), .wdata(qmcs_bus_if_inst.wdata),
        .rdata(qmcs_bus_if_inst.rdata), .ack(qmcs_bus_if_inst.ack), .tx_start(tx_start),
        .rx_frame_done(rx_frame_done), .rx_drop(rx_drop), .rx_irq(rx_irq),
        .tx_frame_pointer(tx_frame_pointer), .rx_frame_pointer(rx_frame_pointer));

    // 250 mhz clock
    always #2 pclk = ~pclk;

    // pulse outputs are counted mid-cycle, away from the launching edge
    always @(negedge pclk) begin
        if (tx_start === 1'b1) tx_starts++;
        if (rx_drop === 1'b1) drops++;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one apb transfer; request held until the rising edge that samples pready high, answer taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed: only the hang guard ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, APB_STATUS, 32'h0);
            n++;
        end while (rd[ST_BUSY] !== 1'b0 && n < 200);
        `CHK("busy", 1'b0, rd[ST_BUSY])
    endtask

    task automatic read_rx(input int exp);
        apb(1'b1, APB_CTRL, 32'h4);
        wait_idle();
        apb(1'b0, APB_RX_COUNT, 32'h0);
        `CHK("rx pending", 32'(exp), rd)
    endtask

    // enqueue one frame; a repeated send while pending must not start another
    task automatic send(input logic [12:0] len, input logic fits);
        int s0;
        int n;
        s0 = tx_starts;
        n = 0;
        tx_frame_bytes <= len;
        apb(1'b1, APB_LEN, {19'h0, len});
        apb(1'b1, APB_CTRL, 32'h1);
        if (fits) begin
            while (tx_starts == s0 && n < 100) begin
                @(posedge pclk);
                n++;
            end
            apb(1'b1, APB_CTRL, 32'h1);
            apb(1'b0, APB_STATUS, 32'h0);
            `CHK("busy while pending", 1'b1, rd[ST_BUSY])
            tx_done <= 1'b1;
            @(posedge pclk);
            tx_done <= 1'b0;
        end
        wait_idle();
        apb(1'b0, APB_STATUS, 32'h0);
        if (fits)
            `CHK("tx done flag", 1'b1, rd[ST_TX_DONE])
        `CHK("refused flag", !fits, rd[ST_REFUSED])
        `CHK("enqueue count", s0 + (fits ? 1 : 0), tx_starts)
        apb(1'b0, APB_TX_FREE, 32'h0);
        `CHK("tx free", 32'd4096, rd)
    endtask

    // one received frame; count must hold until the frame is complete
    task automatic rx(input logic [12:0] b);
        int d0;
        d0 = drops;
        rx_frame_bytes <= b;
        read_rx(rx_cnt);
        rx_frame_done <= 1'b1;
        @(posedge pclk);
        rx_frame_done <= 1'b0;
        if (rx_cnt + b + 4 <= 4096) begin
            rx_cnt += b + 4;
            rx_q.push_back(b + 4);
        end else
            d0++;
        repeat (3) @(posedge pclk);
        `CHK("drop count", d0, drops)
        read_rx(rx_cnt);
    endtask

    task automatic release_frame(input logic irq);
        if (rx_q.size() > 0)
            rx_cnt -= rx_q.pop_front();
        apb(1'b1, APB_CTRL, 32'h2);
        wait_idle();
        apb(1'b0, APB_RX_COUNT, 32'h0);
        `CHK("rx after release", 32'(rx_cnt), rd)
        `CHK("rx pointer", 11'h000, rx_frame_pointer)
        `CHK("rx irq", irq, rx_irq)
    endtask

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_frame_bytes = 13'h0;
        tx_done = 1'b0;
        rx_frame_done = 1'b0;
        rx_frame_bytes = 13'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        read_rx(0);
        send(13'd100, 1'b1);
        send(13'd4092, 1'b1);
        send(13'd4093, 1'b0);
        rx(13'd60);
        rx(13'd100);
        // frames have arrived but the interrupt stays low until enabled
        release_frame(1'b0);
        apb(1'b1, APB_CTRL, 32'h8);
        wait_idle();
        `CHK("rx irq enabled", 1'b1, rx_irq)
        rx(13'd3988);
        rx(13'd0);
        release_frame(1'b1);
        release_frame(1'b1);
        release_frame(1'b1);
        tally_and_finish();
    end
endmodule
